// ===== logic/rds_readback_status.sv
// Overview of operation
// - Codes 0-3 read channel data registers
// - Codes 4-7 read channel control registers
// - Codes 8-11 read channel gain registers
// - Codes 12-15 read channel offset registers
// - Codes 16-19 read channel clear-code registers
// - Codes 20-23 read channel slew registers
// - Code 24 status, 25 main, 26 boost
// - Status word is read only
// - Status-on-write shifts status every frame
// - Otherwise status served by normal readback
// - Boost limit flags, also sets output fault
// - Bit 11 holds user toggle value
// - Bit 10 flags last frame check failure
// - Bit 9 high while any channel ramps
// - Bit 8 flags core over-temperature
// - Bits 3-0 flag channel output faults
// - Read frame: RW, chip address, code
// - Selected data leaves in following transfer
// - Toggle bit follows soft register bit 12
// - Status read clears check error, releases pin unless temp or output fault set
module rds_readback_status #(
    parameter logic [4:0]  SOFT_ADDR = rds_pkg::WA_SOFT
) (
    // System clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rstn,
    // Serial link
    input  wire logic                    sclk_link,
    input  wire logic                    sync_n,
    input  wire logic                    sdin,
    output logic                         sdo_out,
    output logic                         sdo_oe,
    // Chip address straps
    input  wire logic                    chip_addr_bit_hi,
    input  wire logic                    chip_addr_bit_lo,
    // Per-channel register contents
    input  wire logic [3:0][15:0]        data_reg_rd,
    input  wire logic [3:0][15:0]        ctrl_reg_rd,
    input  wire logic [3:0][15:0]        gain_reg_rd,
    input  wire logic [3:0][15:0]        offset_reg_rd,
    input  wire logic [3:0][15:0]        clr_code_rd,
    input  wire logic [3:0][15:0]        slew_ctrl_rd,
    // Shared register contents
    input  wire logic [15:0]             main_ctrl_rd,
    input  wire logic [15:0]             dcdc_ctrl_rd,
    input  wire logic                    status_on_write_enable,
    // Fault and activity sources
    input  wire logic                    boost_limit_flag_a,
    input  wire logic                    boost_limit_flag_b,
    input  wire logic                    boost_limit_flag_c,
    input  wire logic                    boost_limit_flag_d,
    input  wire logic                    output_fault_flag_a,
    input  wire logic                    output_fault_flag_b,
    input  wire logic                    output_fault_flag_c,
    input  wire logic                    output_fault_flag_d,
    input  wire logic                    over_temp,
    input  wire logic                    ramp_active,
    input  wire logic                    crc_fail_pulse,
    // Status and fault pin
    output logic [15:0]                  fault_flags,
    output logic                         fault_n_out,
    output logic                         fault_n_oe
);

    // ------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------
    logic [1:0]                  link_rst_ff;
    logic                        link_rstn;
    logic [rds_pkg::CNT_W-1:0]   edge_cnt_ff;
    logic [rds_pkg::SHIFT_W-1:0] rx_shift_ff;
    logic                        sdo_ff;
    logic [rds_pkg::CNT_W-1:0]   nxt_idx;
    logic [23:0]                 tx_frame;
    logic                        nxt_sdo;

    // System-domain state read quasi-statically by the link
    logic [rds_pkg::CNT_W-1:0]   base_ff;
    logic [15:0]                 tx_word_ff;

    always_ff @(posedge sclk_link) begin
        link_rst_ff <= {link_rst_ff[0], rstn};
    end
    assign link_rstn = link_rst_ff[1];

    // Free-running edge count; frame length is a difference, so the
    // link needs no edge outside a frame to restart it
    always_ff @(posedge sclk_link) begin
        if (!link_rstn) begin
            edge_cnt_ff <= '0;
        end else if (!sync_n) begin
            edge_cnt_ff <= edge_cnt_ff + 6'h01;
        end
    end

    always_ff @(posedge sclk_link) begin
        if (!link_rstn) begin
            rx_shift_ff <= '0;
        end else if (!sync_n) begin
            rx_shift_ff <= {rx_shift_ff[rds_pkg::SHIFT_W-2:0], sdin};
        end
    end

    // Readback word: zero pad above 16 data bits, MSB first
    assign tx_frame = {rds_pkg::SDO_PAD, tx_word_ff};

    always_comb begin
        nxt_idx = 6'(edge_cnt_ff - base_ff + 6'h01);
        nxt_sdo = 1'b0;
        if (nxt_idx < rds_pkg::LEN_STD) begin
            nxt_sdo = tx_frame[5'(rds_pkg::LEN_STD - 6'h01 - nxt_idx)];
        end
    end

    // Leftover bit after a full frame is pad zero, the next frame's first bit
    always_ff @(posedge sclk_link) begin
        if (!link_rstn) begin
            sdo_ff <= 1'b0;
        end else if (!sync_n) begin
            sdo_ff <= nxt_sdo;
        end
    end

    assign sdo_out = sdo_ff;
    assign sdo_oe  = ~sync_n;

    // ------------------------------------------------------------
    // Pin filtering into the system domain
    // ------------------------------------------------------------
    logic [rds_pkg::FILT_W-1:0] filt_in;
    logic [rds_pkg::FILT_W-1:0] filt_lvl;
    logic [3:0]                 boost_lvl;
    logic [3:0]                 ofault_lvl;
    logic                       temp_lvl;
    logic                       sync_hi;

    assign filt_in = {sync_n, over_temp,
                      boost_limit_flag_d, boost_limit_flag_c,
                      boost_limit_flag_b, boost_limit_flag_a,
                      output_fault_flag_d, output_fault_flag_c,
                      output_fault_flag_b, output_fault_flag_a};

    rds_pin_filter #(
        .W       (rds_pkg::FILT_W),
        .RST_VAL (rds_pkg::FILT_RST)
    ) u_pin_filter (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .pin_in    (filt_in),
        .pin_level (filt_lvl)
    );

    assign ofault_lvl = filt_lvl[3:0];
    assign boost_lvl  = filt_lvl[7:4];
    assign temp_lvl   = filt_lvl[8];
    assign sync_hi    = filt_lvl[9];

    // ------------------------------------------------------------
    // Frame end and decode
    // ------------------------------------------------------------
    logic                        sync_hi_prev_ff;
    logic                        frame_end;
    logic [rds_pkg::CNT_W-1:0]   frame_len;
    logic [23:0]                 rx_word;
    logic                        len_ok;
    logic                        addr_hit;
    logic                        req_rd;
    logic                        req_wr;
    logic [4:0]                  rd_code;
    logic                        strap_take_ff;
    logic [1:0]                  chip_addr_ff;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sync_hi_prev_ff <= 1'b1;
        end else begin
            sync_hi_prev_ff <= sync_hi;
        end
    end

    // Straps caught on the first edge after reset release
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            strap_take_ff <= 1'b1;
            chip_addr_ff  <= 2'h0;
        end else begin
            strap_take_ff <= 1'b0;
            if (strap_take_ff) begin
                chip_addr_ff <= {chip_addr_bit_hi, chip_addr_bit_lo};
            end
        end
    end

    // Link counters are still once the frame select is seen high
    assign frame_end = sync_hi & ~sync_hi_prev_ff;
    assign frame_len = 6'(edge_cnt_ff - base_ff);
    assign len_ok    = (frame_len == rds_pkg::LEN_STD) || (frame_len == rds_pkg::LEN_CRC);
    // Trailing check byte is dropped; its verdict arrives on crc_fail_pulse
    assign rx_word   = (frame_len == rds_pkg::LEN_CRC) ?
                       rx_shift_ff[rds_pkg::SHIFT_W-1:rds_pkg::CRC_W] : rx_shift_ff[23:0];
    assign addr_hit  = {rx_word[rds_pkg::BIT_AD_HI], rx_word[rds_pkg::BIT_AD_LO]}
                       == chip_addr_ff;
    assign rd_code   = rx_word[rds_pkg::RA_MSB:rds_pkg::RA_LSB];
    assign req_rd    = frame_end & len_ok & addr_hit & rx_word[rds_pkg::BIT_RW];
    assign req_wr    = frame_end & len_ok & addr_hit & ~rx_word[rds_pkg::BIT_RW];

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            base_ff <= '0;
        end else if (frame_end) begin
            base_ff <= edge_cnt_ff;
        end
    end

    // ------------------------------------------------------------
    // Readback select
    // ------------------------------------------------------------
    logic [15:0] sel_data;

    always_comb begin
        sel_data = 16'h0000;
        case (rd_code[4:2])
            rds_pkg::GRP_DATA: sel_data = data_reg_rd[rd_code[1:0]];
            rds_pkg::GRP_CTRL: sel_data = ctrl_reg_rd[rd_code[1:0]];
            rds_pkg::GRP_GAIN: sel_data = gain_reg_rd[rd_code[1:0]];
            rds_pkg::GRP_OFFS: sel_data = offset_reg_rd[rd_code[1:0]];
            rds_pkg::GRP_CLR:  sel_data = clr_code_rd[rd_code[1:0]];
            rds_pkg::GRP_SLEW: sel_data = slew_ctrl_rd[rd_code[1:0]];
            rds_pkg::GRP_MISC: begin
                case (rd_code[1:0])
                    rds_pkg::MISC_STAT: sel_data = fault_flags;
                    rds_pkg::MISC_MAIN: sel_data = main_ctrl_rd;
                    rds_pkg::MISC_DCDC: sel_data = dcdc_ctrl_rd;
                    default:            sel_data = 16'h0000;
                endcase
            end
            default: sel_data = 16'h0000;
        endcase
    end

    // Loaded at frame end, shifted during the next transfer
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tx_word_ff <= rds_pkg::TX_RST;
        end else if (frame_end) begin
            if (status_on_write_enable) begin
                tx_word_ff <= fault_flags;
            end else if (req_rd) begin
                tx_word_ff <= sel_data;
            end else begin
                tx_word_ff <= 16'h0000;
            end
        end
    end

    // Marks a transfer that carries the status word
    logic status_due_ff;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            status_due_ff <= 1'b0;
        end else if (frame_end) begin
            status_due_ff <= status_on_write_enable | (req_rd & (rd_code == rds_pkg::RA_STATUS));
        end
    end

    // ------------------------------------------------------------
    // Status register: host writes reach only bit 11, via the soft register
    // ------------------------------------------------------------
    logic [15:0] fault_flags_ff;
    logic [15:0] nxt_fault_flags;
    logic        status_read;
    logic        soft_wr;

    assign status_read = frame_end & status_due_ff;
    assign soft_wr     = req_wr & (rd_code == SOFT_ADDR);

    always_comb begin
        nxt_fault_flags = 16'h0000;
        nxt_fault_flags[rds_pkg::ST_BOOST_LSB +: 4] = boost_lvl;
        nxt_fault_flags[rds_pkg::ST_TOGGLE] = soft_wr ? rx_word[rds_pkg::BIT_TOG_W]
                                            : fault_flags_ff[rds_pkg::ST_TOGGLE];
        // Set wins over the read clear
        nxt_fault_flags[rds_pkg::ST_FRAME_CHK] = crc_fail_pulse
            | (fault_flags_ff[rds_pkg::ST_FRAME_CHK] & ~status_read);
        nxt_fault_flags[rds_pkg::ST_RAMP] = ramp_active;
        nxt_fault_flags[rds_pkg::ST_TEMP] = temp_lvl;
        nxt_fault_flags[rds_pkg::ST_FAULT_LSB +: 4] = ofault_lvl | boost_lvl;
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            fault_flags_ff <= rds_pkg::STATUS_RST;
        end else begin
            fault_flags_ff <= nxt_fault_flags;
        end
    end

    assign fault_flags = fault_flags_ff;

    // ------------------------------------------------------------
    // Open-drain fault pin
    // ------------------------------------------------------------
    logic fault_oe_ff;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            fault_oe_ff <= 1'b0;
        end else begin
            fault_oe_ff <= (|fault_flags_ff[rds_pkg::ST_FAULT_LSB +: 4])
                         | fault_flags_ff[rds_pkg::ST_FRAME_CHK]
                         | fault_flags_ff[rds_pkg::ST_TEMP];
        end
    end

    assign fault_n_out = 1'b0;
    assign fault_n_oe  = fault_oe_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    chk_data_sel: assert property (
        req_rd && !status_on_write_enable && rd_code[4:2] == rds_pkg::GRP_DATA
        |=> tx_word_ff == $past(data_reg_rd[rd_code[1:0]]))
        else $error("data register readback wrong");

    chk_ctrl_sel: assert property (
        req_rd && !status_on_write_enable && rd_code[4:2] == rds_pkg::GRP_CTRL
        |=> tx_word_ff == $past(ctrl_reg_rd[rd_code[1:0]]))
        else $error("control register readback wrong");

    chk_gain_sel: assert property (
        req_rd && !status_on_write_enable && rd_code[4:2] == rds_pkg::GRP_GAIN
        |=> tx_word_ff == $past(gain_reg_rd[rd_code[1:0]]))
        else $error("gain register readback wrong");

    chk_offs_sel: assert property (
        req_rd && !status_on_write_enable && rd_code[4:2] == rds_pkg::GRP_OFFS
        |=> tx_word_ff == $past(offset_reg_rd[rd_code[1:0]]))
        else $error("offset register readback wrong");

    chk_clr_sel: assert property (
        req_rd && !status_on_write_enable && rd_code[4:2] == rds_pkg::GRP_CLR
        |=> tx_word_ff == $past(clr_code_rd[rd_code[1:0]]))
        else $error("clear code readback wrong");

    chk_slew_sel: assert property (
        req_rd && !status_on_write_enable && rd_code[4:2] == rds_pkg::GRP_SLEW
        |=> tx_word_ff == $past(slew_ctrl_rd[rd_code[1:0]]))
        else $error("slew register readback wrong");

    chk_main_sel: assert property (
        req_rd && !status_on_write_enable && rd_code == {rds_pkg::GRP_MISC, rds_pkg::MISC_MAIN}
        |=> tx_word_ff == $past(main_ctrl_rd))
        else $error("main control readback wrong");

    chk_stat_write: assert property (
        frame_end && status_on_write_enable |=> tx_word_ff == $past(fault_flags))
        else $error("status not returned during write");

    chk_unmapped_zero: assert property (
        req_rd && !status_on_write_enable && rd_code > rds_pkg::RA_LAST
        |=> tx_word_ff == 16'h0000)
        else $error("unmapped code not zero");

    chk_check_set: assert property (
        crc_fail_pulse |=> fault_flags[rds_pkg::ST_FRAME_CHK] ##1 fault_n_oe)
        else $error("frame check error not flagged");

    chk_check_clear: assert property (
        status_read && !crc_fail_pulse |=> !fault_flags[rds_pkg::ST_FRAME_CHK])
        else $error("status read did not clear check error");

    chk_boost_fault: assert property (
        (fault_flags[15:12] & ~fault_flags[3:0]) == 4'h0)
        else $error("boost flag without output fault");

    chk_toggle_wr: assert property (
        soft_wr |=> fault_flags[rds_pkg::ST_TOGGLE] == $past(rx_word[rds_pkg::BIT_TOG_W]))
        else $error("user toggle not updated");

    chk_pad_zero: assert property (
        fault_flags[7:4] == 4'h0)
        else $error("undefined status bits not zero");

endmodule

// ===== logic/rds_pkg.sv
package rds_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int NCH     = 4;
    localparam int DATA_W  = 16;
    localparam int SHIFT_W = 32;
    localparam int CNT_W   = 6;

    // ------------------------------------------------------------
    // Frame lengths and field positions
    // ------------------------------------------------------------
    localparam logic [5:0] LEN_STD   = 6'h18;
    localparam logic [5:0] LEN_CRC   = 6'h20;
    localparam int         CRC_W     = 8;
    localparam int         BIT_RW    = 23;
    localparam int         BIT_AD_HI = 22;
    localparam int         BIT_AD_LO = 21;
    localparam int         RA_MSB    = 20;
    localparam int         RA_LSB    = 16;
    localparam int         BIT_TOG_W = 12;

    // ------------------------------------------------------------
    // Read address codes, grouped by the upper three bits
    // ------------------------------------------------------------
    localparam logic [2:0] GRP_DATA  = 3'h0;
    localparam logic [2:0] GRP_CTRL  = 3'h1;
    localparam logic [2:0] GRP_GAIN  = 3'h2;
    localparam logic [2:0] GRP_OFFS  = 3'h3;
    localparam logic [2:0] GRP_CLR   = 3'h4;
    localparam logic [2:0] GRP_SLEW  = 3'h5;
    localparam logic [2:0] GRP_MISC  = 3'h6;
    localparam logic [1:0] MISC_STAT = 2'h0;
    localparam logic [1:0] MISC_MAIN = 2'h1;
    localparam logic [1:0] MISC_DCDC = 2'h2;
    localparam logic [4:0] RA_STATUS = 5'h18;
    localparam logic [4:0] RA_LAST   = 5'h1A;
    localparam logic [4:0] WA_SOFT   = 5'h1C;

    // ------------------------------------------------------------
    // Status word layout and reset values
    // ------------------------------------------------------------
    localparam int ST_BOOST_LSB = 12;
    localparam int ST_TOGGLE    = 11;
    localparam int ST_FRAME_CHK = 10;
    localparam int ST_RAMP      = 9;
    localparam int ST_TEMP      = 8;
    localparam int ST_FAULT_LSB = 0;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [15:0] TX_RST     = 16'h0000;
    localparam logic [7:0]  SDO_PAD    = 8'h00;

    // ------------------------------------------------------------
    // Pin filter: frame select idles high, flags idle low
    // ------------------------------------------------------------
    localparam int          FILT_W   = 10;
    localparam logic [9:0]  FILT_RST = 10'h200;

endpackage

// ===== logic/rds_pin_filter.sv
module rds_pin_filter #(
    parameter int               W       = 1,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    // Clock and reset
    input  wire logic           clk_sys,
    input  wire logic           rstn,
    // Asynchronous pins and filtered levels
    input  wire logic [W-1:0]   pin_in,
    output logic      [W-1:0]   pin_level
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] level_ff;

    always_ff @(posedge clk_sys) begin
        meta_ff <= pin_in;
        s2_ff   <= meta_ff;
        s3_ff   <= s2_ff;
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            level_ff <= RST_VAL;
        end else begin
            level_ff <= (s2_ff & ~(s2_ff ^ s3_ff)) | (level_ff & (s2_ff ^ s3_ff));
        end
    end

    assign pin_level = level_ff;

endmodule

// ===== testbench/rds_host_model.sv
module rds_host_model (
    // Link pins driven by the host
    output logic      sclk_link,
    output logic      sync_n,
    output logic      sdin,
    // Device answer
    input  wire logic sdo_out,
    input  wire logic sdo_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclk_link = 1'b0;
        sync_n    = 1'b1;
        sdin      = 1'b0;
    end

    // Idle edges with sync_n high, only around reset: the link's reset
    // synchroniser needs two edges to see rstn rise, or a frame loses bits
    task automatic ticks();
        repeat (4) begin
            #80 sclk_link = 1'b1;
            #80 sclk_link = 1'b0;
        end
    endtask

    // One 24-bit frame, MSB first; clock stands still outside it
    task automatic frame(input logic [23:0] w, output logic [23:0] rx);
        sync_n = 1'b0;
        for (int k = 0; k < 24; k++) begin
            sdin = w[23-k];
            #80;
            rx[23-k] = (sdo_oe === 1'b1) ? sdo_out : 1'bx;
            sclk_link = 1'b1;
            #80 sclk_link = 1'b0;
        end
        #80 sync_n = 1'b1;
        // Released line must not keep showing the last bit
        sdin = ~sdin;
        #300;
    endtask
endmodule

// ===== testbench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                clk_sys = 1'b0;
    logic                rstn = 1'b0;
    logic                sclk_link, sync_n, sdin, sdo_out, sdo_oe, fault_n_out, fault_n_oe;
    logic                chip_addr_bit_hi = 1'b1;
    logic                chip_addr_bit_lo = 1'b0;
    logic [3:0][15:0]    data_reg_rd, ctrl_reg_rd, gain_reg_rd;
    logic [3:0][15:0]    offset_reg_rd, clr_code_rd, slew_ctrl_rd;
    logic [15:0]         main_ctrl_rd = 16'h7A5C;
    logic [15:0]         dcdc_ctrl_rd = 16'h8E01;
    logic [15:0]         fault_flags;
    logic                status_on_write_enable = 1'b0;
    logic                boost_limit_flag_a = 1'b0, boost_limit_flag_b = 1'b0;
    logic                boost_limit_flag_c = 1'b0, boost_limit_flag_d = 1'b0;
    logic                output_fault_flag_a = 1'b0, output_fault_flag_b = 1'b0;
    logic                output_fault_flag_c = 1'b0, output_fault_flag_d = 1'b0;
    logic                over_temp = 1'b0, ramp_active = 1'b0, crc_fail_pulse = 1'b0;
    logic [23:0]         rx;
    int                  fails = 0;
    int                  n_checks = 0;
    int                  cyc = 0;

    always #5 clk_sys = ~clk_sys;

    rds_host_model host_u (.sclk_link, .sync_n, .sdin, .sdo_out, .sdo_oe);

    rds_readback_status dut_u (
        .clk_sys, .rstn, .sclk_link, .sync_n, .sdin, .sdo_out, .sdo_oe,
        .chip_addr_bit_hi, .chip_addr_bit_lo, .data_reg_rd, .ctrl_reg_rd,
        .gain_reg_rd, .offset_reg_rd, .clr_code_rd, .slew_ctrl_rd,
        .main_ctrl_rd, .dcdc_ctrl_rd, .status_on_write_enable,
        .boost_limit_flag_a, .boost_limit_flag_b, .boost_limit_flag_c,
        .boost_limit_flag_d, .output_fault_flag_a, .output_fault_flag_b,
        .output_fault_flag_c, .output_fault_flag_d, .over_temp, .ramp_active,
        .crc_fail_pulse, .fault_flags, .fault_n_out, .fault_n_oe
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic [1:0] ad, input logic rw, input logic [4:0] code,
                        input logic [15:0] d);
        host_u.frame({rw, ad, code, d}, rx);
    endtask

    task automatic cyc_wait(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    function automatic logic [15:0] reg_val(input logic [4:0] c);
        case (c[4:2])
            3'h0: return data_reg_rd[c[1:0]];
            3'h1: return ctrl_reg_rd[c[1:0]];
            3'h2: return gain_reg_rd[c[1:0]];
            3'h3: return offset_reg_rd[c[1:0]];
            3'h4: return clr_code_rd[c[1:0]];
            3'h5: return slew_ctrl_rd[c[1:0]];
            3'h6: return (c[1:0] == 2'h1) ? main_ctrl_rd :
                         (c[1:0] == 2'h2) ? dcdc_ctrl_rd : 16'h0000;
            default: return 16'h0000;
        endcase
    endfunction

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 4; i++) begin
            data_reg_rd[i]   = 16'h1A00 + 16'(i);
            ctrl_reg_rd[i]   = 16'h2B10 + 16'(i);
            gain_reg_rd[i]   = 16'h3C20 + 16'(i);
            offset_reg_rd[i] = 16'h4D30 + 16'(i);
            clr_code_rd[i]   = 16'h5E40 + 16'(i);
            slew_ctrl_rd[i]  = 16'h6F50 + 16'(i);
        end
        // Link flops need clock edges of their own while reset is held
        fork
            host_u.ticks();
            cyc_wait(16);
        join
        @(posedge clk_sys) rstn <= 1'b1;
        host_u.ticks();
        cyc_wait(8);
        // Every code, back to back; filler is a read of data code 0
        xfer(2'h2, 1'b1, 5'h00, 16'h0000);
        for (int c = 1; c <= 32; c++) begin
            xfer(2'h2, 1'b1, 5'(c), 16'h0000);
            check(rx, {8'h00, reg_val(5'(c - 1))});
        end
        $display("test decode done");
        @(posedge clk_sys);
        boost_limit_flag_b <= 1'b1;
        output_fault_flag_c <= 1'b1;
        over_temp <= 1'b1;
        ramp_active <= 1'b1;
        cyc_wait(10);
        check({8'h00, fault_flags}, 24'h002306);
        check({22'h0, fault_n_oe, fault_n_out}, 24'h000002);
        xfer(2'h2, 1'b1, 5'h18, 16'h0000);
        xfer(2'h2, 1'b1, 5'h1F, 16'h0000);
        check(rx, 24'h002306);
        @(posedge clk_sys);
        boost_limit_flag_b <= 1'b0;
        output_fault_flag_c <= 1'b0;
        over_temp <= 1'b0;
        ramp_active <= 1'b0;
        cyc_wait(10);
        check({7'h0, fault_n_oe, fault_flags}, 24'h000000);
        $display("test flags done");
        xfer(2'h2, 1'b0, 5'h1C, 16'h1000);
        cyc_wait(10);
        check({8'h00, fault_flags}, 24'h000800);
        xfer(2'h2, 1'b0, 5'h18, 16'hFFFF);
        cyc_wait(10);
        check({8'h00, fault_flags}, 24'h000800);
        xfer(2'h2, 1'b0, 5'h1C, 16'h0000);
        cyc_wait(10);
        check({8'h00, fault_flags}, 24'h000000);
        $display("test toggle done");
        @(posedge clk_sys) crc_fail_pulse <= 1'b1;
        @(posedge clk_sys) crc_fail_pulse <= 1'b0;
        cyc_wait(3);
        check({7'h0, fault_n_oe, fault_flags}, 24'h010400);
        xfer(2'h2, 1'b1, 5'h18, 16'h0000);
        xfer(2'h2, 1'b1, 5'h1F, 16'h0000);
        check(rx, 24'h000400);
        cyc_wait(10);
        check({7'h0, fault_n_oe, fault_flags}, 24'h000000);
        $display("test check error done");
        @(posedge clk_sys);
        status_on_write_enable <= 1'b1;
        over_temp <= 1'b1;
        cyc_wait(10);
        xfer(2'h2, 1'b0, 5'h00, 16'h1234);
        xfer(2'h2, 1'b1, 5'h00, 16'h0000);
        check(rx, 24'h000100);
        xfer(2'h2, 1'b1, 5'h1F, 16'h0000);
        check(rx, 24'h000100);
        @(posedge clk_sys);
        status_on_write_enable <= 1'b0;
        over_temp <= 1'b0;
        cyc_wait(10);
        xfer(2'h2, 1'b1, 5'h1F, 16'h0000);
        xfer(2'h1, 1'b1, 5'h19, 16'h0000);
        xfer(2'h2, 1'b1, 5'h1F, 16'h0000);
        check(rx, 24'h000000);
        $display("test status on write done");
        final_report();
    end
endmodule
